// File: hw/fgwd_decoder.sv
// Field gap write decoder: gap interval to bits, frame check, programming request
`include "fgwd_params.svh"
`timescale 1ns/1ps
`default_nettype none
module fgwd_decoder
  import fgwd_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = (`FGWD_PROG_TIME_US * 200)
)
(
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  fieldClk,
  input  wire logic  gapDet,
  output logic       readMode,
  output logic       decodeErr,
  output logic       progStart,
  output fgwd_word_t progWord,
  input  wire logic  progReady,
  output logic       progBusy
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  // All state lives in one record; the combinational block fills a copy
  typedef struct packed {
    logic [1:0]  fclkSync;
    logic [1:0]  gapSync;
    logic        fclkPrev;
    logic        gapPrev;
    fgwd_mode_t  mode;
    logic        started;
    logic [7:0]  interval;
    logic [5:0]  bitCnt;
    logic [37:0] shift;
    logic [31:0] progCnt;
    logic        wordValid;
    logic        readMode;
    logic        decodeErr;
    logic        progStart;
    fgwd_word_t  progWord;
    logic        progBusy;
  } fgwd_state_t;

  fgwd_state_t st_r;
  fgwd_state_t st_nxt;
  logic        bufInReady;
  logic        bufOutValid;
  fgwd_word_t  bufOutWord;
  logic        fclkRise;
  logic        gapRise;
  fgwd_sym_t   sym;

  // ----------------------------------------------------------------------
  // Interval classification
  // ----------------------------------------------------------------------
  // Both window edges are inclusive; every other count is an error symbol
  function automatic fgwd_sym_t classify(input logic [7:0] cnt);
    if (cnt >= `FGWD_ZERO_MIN && cnt <= `FGWD_ZERO_MAX) begin
      return FgwdSymZero;
    end else if (cnt >= `FGWD_ONE_MIN && cnt <= `FGWD_ONE_MAX) begin
      return FgwdSymOne;
    end
    return FgwdSymErr;
  endfunction

  // ----------------------------------------------------------------------
  // Word buffer
  // ----------------------------------------------------------------------
  // Two entries let a finished frame wait while the programming side stalls,
  // but the decoder still ignores gaps in FgwdProg until the buffer is empty and the timer has run out.
  fgwd_buf fgwd_buf_inst (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (st_r.wordValid),
    .inReady  (bufInReady),
    .inWord   ({st_r.shift[3:0], st_r.shift[35:4]}),
    .outValid (bufOutValid),
    .outReady (progReady && !st_r.progBusy),
    .outWord  (bufOutWord)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt           = st_r;
    // Both pins come from the field side: two flops each before any edge logic
    st_nxt.fclkSync  = {st_r.fclkSync[0], fieldClk};
    st_nxt.gapSync   = {st_r.gapSync[0], gapDet};
    st_nxt.fclkPrev  = st_r.fclkSync[1];
    st_nxt.gapPrev   = st_r.gapSync[1];
    st_nxt.decodeErr = 1'b0;
    st_nxt.progStart = 1'b0;
    fclkRise = st_r.fclkSync[1] && !st_r.fclkPrev;
    gapRise  = st_r.gapSync[1] && !st_r.gapPrev;
    sym      = classify(st_r.interval);

    // Field clocks still arrive while the coil decays, so they are counted
    // until the gap detector fires; saturate so long idle never wraps.
    if (fclkRise && st_r.interval != `FGWD_CNT_SAT) begin
      st_nxt.interval = st_r.interval + 8'h01;
    end
    if (st_r.wordValid && bufInReady) begin
      st_nxt.wordValid = 1'b0;
    end

    // ----------------------------------------------------------------------
    // Frame decode
    // ----------------------------------------------------------------------
    case (st_r.mode)
      FgwdRead: begin
        st_nxt.readMode = 1'b1;
        if (gapRise) begin
          // The start gap carries no bit; it only arms the interval counter
          st_nxt.mode     = FgwdWrite;
          st_nxt.started  = 1'b1;
          st_nxt.interval = 8'h00;
          st_nxt.bitCnt   = 6'h00;
          st_nxt.readMode = 1'b0;
        end
      end
      FgwdWrite: begin
        if (gapRise) begin
          st_nxt.interval = 8'h00;
          if (sym == FgwdSymErr) begin
            // A symbol outside both windows ends the write at once
            st_nxt.mode      = FgwdRead;
            st_nxt.decodeErr = 1'b1;
            st_nxt.readMode  = 1'b1;
          end else begin
            st_nxt.shift  = {st_r.shift[36:0], sym == FgwdSymOne};
            st_nxt.bitCnt = st_r.bitCnt + 6'h01;
            // The opcode is complete at the second bit; a wrong one aborts here
            if (st_r.bitCnt == 6'h01 &&
                {st_r.shift[0], sym == FgwdSymOne} != `FGWD_OPCODE_WRITE) begin
              st_nxt.mode      = FgwdRead;
              st_nxt.decodeErr = 1'b1;
              st_nxt.readMode  = 1'b1;
            end
          end
        end else if (st_r.interval > `FGWD_ONE_MAX) begin
          // No further gap: frame ended; accept only an exact bit count
          // The field stays on past the one window, so no bit can follow
          if (st_r.bitCnt == `FGWD_FRAME_BITS && !st_r.wordValid) begin
            st_nxt.wordValid = 1'b1;
            st_nxt.mode      = FgwdProg;
          end else begin
            st_nxt.mode      = FgwdRead;
            st_nxt.readMode  = 1'b1;
            st_nxt.decodeErr = (st_r.bitCnt != `FGWD_FRAME_BITS);
          end
        end
      end
      FgwdProg: begin
        // Stay here until the word has left the buffer and the timer ran out
        if (!st_r.wordValid && !bufOutValid && !st_r.progBusy) begin
          st_nxt.mode     = FgwdRead;
          st_nxt.readMode = 1'b1;
        end
      end
      default: begin
        st_nxt.mode = FgwdRead;
      end
    endcase

    // ----------------------------------------------------------------------
    // Programming timer
    // ----------------------------------------------------------------------
    // The timer stands in for the memory write time; a word waits in the
    // buffer until it has run out, so two blocks are never written at once.
    if (st_r.progBusy) begin
      if (st_r.progCnt == 32'h0000_0001) begin
        st_nxt.progBusy = 1'b0;
      end
      st_nxt.progCnt = st_r.progCnt - 32'h0000_0001;
    end else if (bufOutValid && progReady) begin
      // Hand a word over only while the programming side is idle and ready
      st_nxt.progStart = 1'b1;
      st_nxt.progWord  = bufOutWord;
      st_nxt.progBusy  = 1'b1;
      st_nxt.progCnt   = PROG_CYCLES;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Reset lands in read mode, so the ID code goes out from power-up
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r          <= '0;
      st_r.readMode <= 1'b1;
      st_r.mode     <= FgwdRead;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Every output is a register field; nothing combinational reaches a pin
  assign readMode  = st_r.readMode;
  assign decodeErr = st_r.decodeErr;
  assign progStart = st_r.progStart;
  assign progWord  = st_r.progWord;
  assign progBusy  = st_r.progBusy;
endmodule
`default_nettype wire

// File: hw/fgwd_params.svh
// Constants of the field gap write decoder
`ifndef FGWD_PARAMS_SVH
`define FGWD_PARAMS_SVH
`define FGWD_OPCODE_WRITE   2'h2
`define FGWD_OPCODE_BITS    6'h02
`define FGWD_DATA_BITS      6'h20
`define FGWD_ADDR_BITS      6'h04
`define FGWD_FRAME_BITS     6'h26
`define FGWD_ZERO_MIN       8'h10
`define FGWD_ZERO_MAX       8'h1f
`define FGWD_ONE_MIN        8'h30
`define FGWD_ONE_MAX        8'h3f
`define FGWD_CNT_SAT        8'hff
`define FGWD_PROG_TIME_US   16000
`endif

// File: hw/fgwd_pkg.sv
// Types of the field gap write decoder
package fgwd_pkg;
  typedef enum logic [1:0] {FgwdRead, FgwdWrite, FgwdProg} fgwd_mode_t;
  typedef enum logic [1:0] {FgwdSymZero, FgwdSymOne, FgwdSymErr} fgwd_sym_t;
  typedef struct packed {
    logic [3:0]  blockAddr;
    logic [31:0] payload;
  } fgwd_word_t;
endpackage

// File: hw/fgwd_buf.sv
// Two-entry valid/ready buffer for decoded write words
`timescale 1ns/1ps
`default_nettype none
module fgwd_buf
  import fgwd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       inValid,
  output logic            inReady,
  input  wire fgwd_word_t inWord,
  output logic            outValid,
  input  wire logic       outReady,
  output fgwd_word_t      outWord
);
  typedef struct packed {
    fgwd_word_t [1:0] mem;
    logic             wrPtr;
    logic             rdPtr;
    logic [1:0]       count;
  } fgwd_buf_state_t;

  fgwd_buf_state_t st_r;
  fgwd_buf_state_t st_nxt;
  logic            doWr;
  logic            doRd;

  always_comb begin
    st_nxt = st_r;
    doWr   = inValid && (st_r.count != 2'h2);
    doRd   = outReady && (st_r.count != 2'h0);
    if (doWr) begin
      st_nxt.mem[st_r.wrPtr] = inWord;
      st_nxt.wrPtr = ~st_r.wrPtr;
    end
    if (doRd) begin
      st_nxt.rdPtr = ~st_r.rdPtr;
    end
    st_nxt.count = st_r.count + {1'b0, doWr} - {1'b0, doRd};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign inReady  = (st_r.count != 2'h2);
  assign outValid = (st_r.count != 2'h0);
  assign outWord  = st_r.mem[st_r.rdPtr];
endmodule
`default_nettype wire

// File: bench/fgwd_decoder_chk.sv
// Port checker of the field gap write decoder
`timescale 1ns/1ps
`default_nettype none
module fgwd_decoder_chk
  import fgwd_pkg::*;
#(parameter int unsigned PROG_CYCLES = 20)
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       readMode,
  input wire logic       decodeErr,
  input wire logic       progStart,
  input wire fgwd_word_t progWord,
  input wire logic       progBusy
);
  int unsigned busyCnt;
  always_ff @(posedge clk) begin
    busyCnt <= (rst_n && progBusy) ? busyCnt + 1 : 0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence sLaunch;
    progStart ##1 progBusy;
  endsequence
  sequence sBackToRead;
    ##[0:4] readMode;
  endsequence
  a_start_launch: assert property (progStart |-> sLaunch)
    else $error("busy missing after start");
  a_start_pulse: assert property (progStart |=> !progStart)
    else $error("start longer than one cycle");
  a_start_clean: assert property (!(progStart && decodeErr))
    else $error("start together with error");
  a_err_read: assert property (decodeErr |-> sBackToRead)
    else $error("no read mode after error");
  a_err_pulse: assert property (decodeErr |=> !decodeErr)
    else $error("error longer than one cycle");
  a_busy_len: assert property ($fell(progBusy) |-> busyCnt == PROG_CYCLES)
    else $error("busy length wrong");
  a_busy_write: assert property (progBusy |-> !readMode)
    else $error("read mode while programming");
  a_done_read: assert property ($fell(progBusy) |-> sBackToRead)
    else $error("no read mode after programming");
  a_reset_read: assert property ($rose(rst_n) |-> readMode)
    else $error("not in read mode after reset");
  a_word_held: assert property ($changed(progWord) |-> progStart)
    else $error("word changed without start");
endmodule
bind fgwd_decoder fgwd_decoder_chk #(.PROG_CYCLES(PROG_CYCLES)) fgwd_decoder_chk_inst (
  .clk(clk), .rst_n(rst_n), .readMode(readMode), .decodeErr(decodeErr),
  .progStart(progStart), .progWord(progWord), .progBusy(progBusy));
`default_nettype wire

// File: bench/fgwd_base_station.sv
// Base station model that switches the field to send gap-coded frames
`timescale 1ns/1ps
`default_nettype none
module fgwd_base_station (
  output logic fieldClk,
  output logic gapDet
);
  initial begin
    fieldClk = 1'b0;
    gapDet = 1'b0;
  end
  // Field on for n clocks; n already includes the decay pulses before detection
  task automatic field(input int n);
    repeat (n) begin
      #32 fieldClk <= 1'b1;
      #32 fieldClk <= 1'b0;
    end
  endtask
  // Long gap, as a high-Q coil needs; the field clock stops meanwhile
  task automatic gap();
    gapDet <= 1'b1;
    #400 gapDet <= 1'b0;
  endtask
  // Start gap, n bits MSB first; no closing field after an early abort
  task automatic frame(input logic [37:0] f, input int n, input int badLen);
    // Field on before the start gap keeps gap edges of back-to-back frames apart
    field(20);
    gap();
    for (int i = 37; i > 37 - n; i--) begin
      field(badLen != 0 ? badLen : f[i] ? 48 + $urandom % 16 : 16 + $urandom % 16);
      gap();
    end
    if (n > 2) field(70);
  endtask
endmodule
`default_nettype wire

// File: bench/tb_fgwd_decoder.sv
// Self-checking bench of the field gap write decoder
`timescale 1ns/1ps
`default_nettype none
module tb_fgwd_decoder
  import fgwd_pkg::*;
;
  localparam logic [36:0] ERR = 37'h10_0000_0000;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        progReady = 1'b0;
  logic        fieldClk, gapDet, readMode, decodeErr, progStart, progBusy;
  fgwd_word_t  progWord;
  logic [36:0] expQ[$];
  logic [37:0] f;
  int          errors = 0;
  int          n_tests = 0;
  always #2.5 clk = ~clk;
  fgwd_decoder #(.PROG_CYCLES(20)) fgwd_decoder_inst (.clk(clk), .rst_n(rst_n),
    .fieldClk(fieldClk), .gapDet(gapDet), .readMode(readMode), .decodeErr(decodeErr),
    .progStart(progStart), .progWord(progWord), .progReady(progReady), .progBusy(progBusy));
  fgwd_base_station fgwd_base_station_inst (.fieldClk(fieldClk), .gapDet(gapDet));
  task automatic check(input logic [36:0] got, input logic [36:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic settle();
    int k;
    for (k = 0; k < 4000 && (expQ.size() != 0 || readMode !== 1'b1); k++) @(posedge clk);
    check({35'h0, expQ.size() != 0, readMode}, 37'h1);
    $display("test done at %0t", $time);
  endtask
  // Random stalls of the programming side
  always @(posedge clk) progReady <= ($urandom % 4) != 0;
  always @(posedge clk) begin
    if (rst_n && (progStart || decodeErr))
      check({decodeErr, decodeErr ? 36'h0 : progWord}, expQ.size() ? expQ.pop_front() : 'x);
  end
  initial begin
    void'($urandom(98));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check({36'h0, readMode}, 37'h1);
    f = {2'b10, $urandom, 4'($urandom)};
    expQ.push_back({1'b0, f[3:0], f[35:4]});
    fgwd_base_station_inst.frame(f, 38, 0);
    settle();
    expQ.push_back(ERR);
    fgwd_base_station_inst.frame({2'b01, 36'h0}, 2, 0);
    settle();
    // Intervals just below the zero window and just below the one window
    for (int i = 0; i < 2; i++) begin
      expQ.push_back(ERR);
      fgwd_base_station_inst.frame(f, 1, (i == 0) ? 15 : 47);
      settle();
    end
    expQ.push_back(ERR);
    fgwd_base_station_inst.frame({2'b10, $urandom, 4'h5}, 37, 0);
    settle();
    print_verdict();
  end
  // Two long frames at about 3 us a bit plus the short ones need near 250 us
  initial begin
    #400us;
    errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
